// ===== scurve_cfg.svh
// Constants for the S-curve acceleration profile generator
`ifndef SCURVE_CFG_SVH
`define SCURVE_CFG_SVH
// Fixed-point fraction bits carried on speed and acceleration
`define FRAC_BITS 16
// Divisor turning the jerk setting into a fraction of the rate
`define JERK_DIV 100
// Jerk settings that select S-curve shaping
`define JERK_MIN 16'h0001
`define JERK_MAX 16'h1388
// Control tick period in microseconds and clock rate in MHz
`define TICK_US 1000
`define CLK_MHZ 125
// Cycles per control tick, derived from the two figures above
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
// Control ticks per second
`define TICK_HZ (1000000 / `TICK_US)
// Reset values
`define SPEED_RST 32'h0000_0000
`define ACCEL_RST 32'h0000_0000
`endif

// ===== scurve_pkg.sv
// Types shared by the S-curve profile generator
package scurve_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_CONST = 3'b010,
    ST_RISE = 3'b011,
    ST_HOLD = 3'b100,
    ST_FALL = 3'b101
  } state_t;
  typedef enum logic [1:0] {
    SHP_NONE = 2'b00,
    SHP_LINEAR = 2'b01,
    SHP_TRIANGLE = 2'b10,
    SHP_TRAPEZOID = 2'b11
  } shape_t;
endpackage

// ===== rate_if.sv
// Per-tick rate increments passed from the rate calculator to the profiler
`timescale 1ns/100ps
interface rate_if;
  logic [63:0] jerk_inc;
  logic [63:0] accel_max;
  logic s_curve;
  modport calc (output jerk_inc, output accel_max, output s_curve);
  modport user (input jerk_inc, input accel_max, input s_curve);
endinterface

// ===== scurve_rate_calc.sv
// Converts jerk setting and rate into fixed-point per-tick increments
`timescale 1ns/100ps
`include "scurve_cfg.svh"
module scurve_rate_calc (
  // Clocking
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Selected profile values
  input wire logic [15:0] jerk_set,
  input wire logic [31:0] rate,
  // Increments out
  rate_if.calc rates
);
  logic [63:0] jinc_r;
  logic [63:0] jinc_nxt;
  logic [63:0] amax_r;
  logic [63:0] amax_nxt;
  logic scv_r;
  logic scv_nxt;
  logic [63:0] prod;

  // Jerk = setting * rate / 100, scaled and spread over one tick
  always_comb
  begin
    prod = (64'(jerk_set) * 64'(rate)) << `FRAC_BITS;
    jinc_nxt = prod / 64'(`JERK_DIV * `TICK_HZ);
    amax_nxt = {32'h0000_0000, rate} << `FRAC_BITS;
    // Out-of-range settings fall back to constant rate
    scv_nxt = (jerk_set >= `JERK_MIN) && (jerk_set <= `JERK_MAX);
    // A jerk too small to register in one tick still advances
    if (scv_nxt && jinc_nxt == 64'h0)
    begin
      jinc_nxt = 64'h1;
    end
  end

  // Registered so the long divide has a full cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      jinc_r <= 64'h0;
      amax_r <= 64'h0;
      scv_r <= 1'b0;
    end
    else if (clk_en)
    begin
      jinc_r <= jinc_nxt;
      amax_r <= amax_nxt;
      scv_r <= scv_nxt;
    end
  end

  assign rates.jerk_inc = jinc_r;
  assign rates.accel_max = amax_r;
  assign rates.s_curve = scv_r;
endmodule

// ===== scurve_accel_profile.sv
// S-curve acceleration and deceleration profile generator
//
// Overview of operation
// - Jerk setting zero gives constant acceleration, speed changing linearly.
// - Physical jerk equals jerk setting times rate divided by 100.
// - S-curve only for jerk settings 1 to 5000; host keeps within range.
// - During ramp, acceleration rises linearly at jerk rate.
// - Jerk reaching programmed acceleration before midpoint holds a plateau.
// - Midpoint acceleration not above programmed gives ramp up then down.
// - Every S-curve phase is symmetric about its speed midpoint.
// - Deceleration shaped from deceleration rate; equal rates give identical phases.
// - Shaping spans starting speed to programmed speed.
// - Jerk below 200/t lengthens phase; above gives trapezoid plateau.
// - Raising jerk above 200/t lengthens plateau; lowering shortens it.
`timescale 1ns/100ps
`include "scurve_cfg.svh"
module scurve_accel_profile #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock, reset and enable
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Move parameters from the host
  input wire logic [31:0] START_SPEED,
  input wire logic [31:0] PROG_SPEED,
  input wire logic [31:0] ACCEL_RATE,
  input wire logic [31:0] DECEL_RATE,
  input wire logic [15:0] JERK_SET,
  // Phase requests
  input wire logic ACCEL_GO,
  input wire logic DECEL_GO,
  // Profile outputs
  output logic [31:0] SPEED,
  output logic [31:0] ACCEL_NOW,
  output logic BUSY,
  output logic DONE,
  output logic [1:0] SHAPE
);
  localparam int FB = `FRAC_BITS;

  rate_if rates ();

  scurve_pkg::state_t state_r;
  scurve_pkg::state_t state_nxt;
  logic [47:0] speed_r;
  logic [47:0] speed_nxt;
  logic [63:0] acc_r;
  logic [63:0] acc_nxt;
  logic [47:0] goal_r;
  logic [47:0] goal_nxt;
  logic [47:0] base_r;
  logic [47:0] base_nxt;
  logic up_r;
  logic up_nxt;
  logic [47:0] s1_r;
  logic [47:0] s1_nxt;
  logic [31:0] rise_r;
  logic [31:0] rise_nxt;
  logic [31:0] fall_r;
  logic [31:0] fall_nxt;
  logic use_decel_r;
  logic use_decel_nxt;
  logic done_r;
  logic done_nxt;
  scurve_pkg::shape_t shape_r;
  scurve_pkg::shape_t shape_nxt;
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic tick;
  logic [47:0] dv;
  logic [47:0] gained;
  logic [47:0] remain;
  logic [47:0] half;
  logic [47:0] step;
  logic [63:0] acc_up;

  // Rate picked from the next direction, so LOAD already sees it registered
  scurve_rate_calc u_rates (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .clk_en(CLK_EN),
    .jerk_set(JERK_SET),
    .rate(use_decel_nxt ? DECEL_RATE : ACCEL_RATE),
    .rates(rates.calc)
  );

  // Fixed control tick divider
  always_comb
  begin
    tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      tick_cnt_r <= 32'h0;
    end
    else if (CLK_EN)
    begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // Profile sequencing and integration
  always_comb
  begin
    state_nxt = state_r;
    speed_nxt = speed_r;
    acc_nxt = acc_r;
    goal_nxt = goal_r;
    base_nxt = base_r;
    up_nxt = up_r;
    s1_nxt = s1_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    use_decel_nxt = use_decel_r;
    done_nxt = 1'b0;
    shape_nxt = shape_r;
    // Speed gain per tick from the acceleration held this tick
    dv = 48'(acc_r / 64'(`TICK_HZ));
    gained = up_r ? speed_r - base_r : base_r - speed_r;
    remain = up_r ? goal_r - speed_r : speed_r - goal_r;
    half = (up_r ? goal_r - base_r : base_r - goal_r) >> 1;
    step = (dv >= remain) ? remain : dv;
    acc_up = acc_r + rates.jerk_inc;
    case (state_r)
      scurve_pkg::ST_IDLE:
      begin
        if (ACCEL_GO || DECEL_GO)
        begin
          // Phase spans starting speed and programmed speed
          up_nxt = ACCEL_GO;
          use_decel_nxt = !ACCEL_GO;
          base_nxt = {ACCEL_GO ? START_SPEED : PROG_SPEED, 16'h0000};
          goal_nxt = {ACCEL_GO ? PROG_SPEED : START_SPEED, 16'h0000};
          speed_nxt = {ACCEL_GO ? START_SPEED : PROG_SPEED, 16'h0000};
          acc_nxt = 64'h0;
          s1_nxt = 48'h0;
          rise_nxt = 32'h0;
          state_nxt = scurve_pkg::ST_LOAD;
        end
      end
      scurve_pkg::ST_LOAD:
      begin
        // Rate calculator settled on the selected rate by now
        if (rates.s_curve)
        begin
          shape_nxt = scurve_pkg::SHP_TRIANGLE;
          state_nxt = scurve_pkg::ST_RISE;
        end
        else
        begin
          acc_nxt = rates.accel_max;
          shape_nxt = scurve_pkg::SHP_LINEAR;
          state_nxt = scurve_pkg::ST_CONST;
        end
      end
      scurve_pkg::ST_CONST:
      begin
        if (tick)
        begin
          speed_nxt = up_r ? speed_r + step : speed_r - step;
          if (step == remain)
          begin
            state_nxt = scurve_pkg::ST_IDLE;
          end
        end
      end
      scurve_pkg::ST_RISE:
      begin
        if (tick)
        begin
          speed_nxt = up_r ? speed_r + step : speed_r - step;
          s1_nxt = gained + step;
          rise_nxt = rise_r + 32'h1;
          if (gained + step >= half)
          begin
            // Midpoint reached while ramping: turn straight down
            fall_nxt = rise_r + 32'h1;
            state_nxt = scurve_pkg::ST_FALL;
          end
          else if (acc_up >= rates.accel_max)
          begin
            // Ramp met the rate early: hold it as a plateau
            acc_nxt = rates.accel_max;
            shape_nxt = scurve_pkg::SHP_TRAPEZOID;
            state_nxt = scurve_pkg::ST_HOLD;
          end
          else
          begin
            acc_nxt = acc_up;
          end
        end
      end
      scurve_pkg::ST_HOLD:
      begin
        if (tick)
        begin
          speed_nxt = up_r ? speed_r + step : speed_r - step;
          // Leave the plateau when the mirrored ramp-down gain remains
          if (remain - step <= s1_r)
          begin
            fall_nxt = rise_r;
            state_nxt = scurve_pkg::ST_FALL;
          end
        end
      end
      scurve_pkg::ST_FALL:
      begin
        if (tick)
        begin
          speed_nxt = up_r ? speed_r + step : speed_r - step;
          acc_nxt = (acc_r > rates.jerk_inc) ? acc_r - rates.jerk_inc : 64'h0;
          fall_nxt = fall_r - 32'h1;
          // Rounding leftovers are closed out on the last tick
          if (fall_r <= 32'h1 || step == remain)
          begin
            speed_nxt = goal_r;
            acc_nxt = 64'h0;
            state_nxt = scurve_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = scurve_pkg::ST_IDLE;
      end
    endcase
    if (state_nxt == scurve_pkg::ST_IDLE && state_r != scurve_pkg::ST_IDLE)
    begin
      acc_nxt = 64'h0;
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      state_r <= scurve_pkg::ST_IDLE;
      speed_r <= 48'h0;
      acc_r <= 64'h0;
      goal_r <= 48'h0;
      base_r <= 48'h0;
      up_r <= 1'b1;
      s1_r <= 48'h0;
      rise_r <= 32'h0;
      fall_r <= 32'h0;
      use_decel_r <= 1'b0;
      done_r <= 1'b0;
      shape_r <= scurve_pkg::SHP_NONE;
    end
    else if (CLK_EN)
    begin
      state_r <= state_nxt;
      speed_r <= speed_nxt;
      acc_r <= acc_nxt;
      goal_r <= goal_nxt;
      base_r <= base_nxt;
      up_r <= up_nxt;
      s1_r <= s1_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      use_decel_r <= use_decel_nxt;
      done_r <= done_nxt;
      shape_r <= shape_nxt;
    end
  end

  // Output registers, integer parts of the fixed-point state
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      SPEED <= `SPEED_RST;
      ACCEL_NOW <= `ACCEL_RST;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      SHAPE <= 2'b00;
    end
    else if (CLK_EN)
    begin
      SPEED <= speed_nxt[FB +: 32];
      ACCEL_NOW <= acc_nxt[FB +: 32];
      BUSY <= (state_nxt != scurve_pkg::ST_IDLE);
      DONE <= done_nxt;
      SHAPE <= shape_nxt;
    end
  end
endmodule

// ===== scurve_accel_profile_sva.sv
// Port-level assertions for the S-curve profile generator
`timescale 1ns/100ps
module scurve_accel_profile_sva #(
  parameter int TICK_CYCLES = 20
) (
  // Clock, reset and enable
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Move parameters
  input wire logic [31:0] START_SPEED,
  input wire logic [31:0] PROG_SPEED,
  input wire logic [31:0] ACCEL_RATE,
  input wire logic [31:0] DECEL_RATE,
  input wire logic [15:0] JERK_SET,
  input wire logic ACCEL_GO,
  input wire logic DECEL_GO,
  // Profile outputs
  input wire logic [31:0] SPEED,
  input wire logic [31:0] ACCEL_NOW,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [1:0] SHAPE
);
  logic dec_r, dec_nxt;
  logic [31:0] goal_r, goal_nxt;
  wire logic [31:0] rate_sel = dec_r ? DECEL_RATE : ACCEL_RATE;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Direction and target of the phase last taken
  always_comb
  begin
    dec_nxt = dec_r;
    goal_nxt = goal_r;
    if (CLK_EN && !BUSY && (ACCEL_GO || DECEL_GO))
    begin
      dec_nxt = !ACCEL_GO;
      goal_nxt = ACCEL_GO ? PROG_SPEED : START_SPEED;
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    dec_r <= RESETN && dec_nxt;
    goal_r <= RESETN ? goal_nxt : 32'h0;
  end
  sequence s_take;
    CLK_EN && !BUSY && (ACCEL_GO || DECEL_GO);
  endsequence
  sequence s_lin_run;
    BUSY && $past(BUSY) && $past(BUSY, 2) && SHAPE == scurve_pkg::SHP_LINEAR;
  endsequence
  property p_take; s_take |=> BUSY; endproperty
  a_take: assert property (p_take) else $error("phase not started");
  property p_done; DONE |-> !BUSY && $past(BUSY); endproperty
  a_done: assert property (p_done) else $error("done without busy fall");
  property p_goal; DONE |-> SPEED == goal_r && ACCEL_NOW == 32'h0; endproperty
  a_goal: assert property (p_goal) else $error("phase ended off target");
  property p_lin; s_lin_run |-> $stable(ACCEL_NOW) && ACCEL_NOW == rate_sel; endproperty
  a_lin: assert property (p_lin) else $error("linear rate not constant");
  property p_cap; BUSY |-> ACCEL_NOW <= rate_sel; endproperty
  a_cap: assert property (p_cap) else $error("acceleration above rate");
  property p_tick;
    (BUSY && $past(BUSY) && $changed(SPEED)) |=> !(BUSY && $changed(SPEED))[*8];
  endproperty
  a_tick: assert property (p_tick) else $error("speed moved between ticks");
  property p_idle; !BUSY && !$past(BUSY) |-> $stable(SPEED) && $stable(SHAPE); endproperty
  a_idle: assert property (p_idle) else $error("idle outputs moved");
  property p_shape;
    $rose(BUSY) |=> SHAPE != scurve_pkg::SHP_NONE
      && ((JERK_SET == 16'h0 || JERK_SET > 16'h1388) == (SHAPE == scurve_pkg::SHP_LINEAR));
  endproperty
  a_shape: assert property (p_shape) else $error("wrong shape class");
endmodule
bind scurve_accel_profile scurve_accel_profile_sva #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .START_SPEED(START_SPEED),
  .PROG_SPEED(PROG_SPEED), .ACCEL_RATE(ACCEL_RATE), .DECEL_RATE(DECEL_RATE),
  .JERK_SET(JERK_SET), .ACCEL_GO(ACCEL_GO), .DECEL_GO(DECEL_GO), .SPEED(SPEED),
  .ACCEL_NOW(ACCEL_NOW), .BUSY(BUSY), .DONE(DONE), .SHAPE(SHAPE));

// ===== scurve_host.sv
// Host model that programs move parameters and launches phases
`timescale 1ns/100ps
module scurve_host (
  // Clock and status
  input wire logic clk,
  input wire logic busy,
  // Bench commands
  input wire logic req,
  input wire logic req_dec,
  input wire logic [15:0] jerk_in,
  input wire logic [31:0] acc_in,
  input wire logic [31:0] dec_in,
  input wire logic [31:0] vs_in,
  input wire logic [31:0] vp_in,
  // Parameters to the profiler
  output logic [15:0] jerk,
  output logic [31:0] acc,
  output logic [31:0] dec,
  output logic [31:0] vs,
  output logic [31:0] vp,
  output logic go_acc,
  output logic go_dec
);
  initial
  begin
    {jerk, acc, dec, vs, vp, go_acc, go_dec} = '0;
  end
  // Parameters only change while idle, as the profiler rereads them mid-phase
  always @(posedge clk)
  begin
    go_acc <= #1 req && !req_dec;
    go_dec <= #1 req && req_dec;
    if (!busy && req)
    begin
      jerk <= #1 (jerk_in > 16'h1388) ? 16'h1388 : jerk_in;
      {acc, dec, vs, vp} <= #1 {acc_in, dec_in, vs_in, vp_in};
    end
  end
endmodule

// ===== scurve_accel_profile_bench.sv
// Self-checking bench for the S-curve profile generator
`timescale 1ns/100ps
module scurve_accel_profile_bench;
  typedef struct {logic [15:0] j; logic [31:0] a, d, vs, vp; logic dn; logic [1:0] sh;} row_t;
  localparam int TCK = 20;
  logic clk = 0, rstn = 0, en = 1, req = 0, rdec = 0, goa, god, busy, done;
  logic [15:0] jin = 0, jerk;
  logic [31:0] ain = 0, din = 0, vsin = 0, vpin = 0, acc, dec, vs, vp, speed, anow;
  logic [1:0] shape;
  int failures = 0, comparisons = 0, n;
  row_t rows [8] = '{
    '{16'h0, 32'he290, 32'he290, 32'h3e8, 32'hfa0, 1'b0, 2'h1},
    '{16'hc8, 32'he290, 32'he290, 32'h3e8, 32'hfa0, 1'b0, 2'h2},
    '{16'hfa0, 32'he290, 32'he290, 32'h3e8, 32'hfa0, 1'b0, 2'h3},
    '{16'h1388, 32'he290, 32'he290, 32'h3e8, 32'hfa0, 1'b0, 2'h3},
    '{16'h1, 32'he290, 32'he290, 32'h64, 32'h82, 1'b0, 2'h2},
    '{16'hc8, 32'he290, 32'he290, 32'h3e8, 32'hfa0, 1'b1, 2'h2},
    '{16'hc8, 32'he290, 32'h7148, 32'h3e8, 32'hfa0, 1'b1, 2'h2},
    '{16'h0, 32'he290, 32'h7148, 32'h3e8, 32'hfa0, 1'b1, 2'h1}};
  always #4 clk = !clk;
  scurve_host host (.clk(clk), .busy(busy), .req(req), .req_dec(rdec), .jerk_in(jin), .acc_in(ain),
    .dec_in(din), .vs_in(vsin), .vp_in(vpin), .jerk(jerk), .acc(acc), .dec(dec), .vs(vs), .vp(vp),
    .go_acc(goa), .go_dec(god));
  scurve_accel_profile #(.TICK_CYCLES(TCK)) uut (.SYS_CLK(clk), .RESETN(rstn), .CLK_EN(en),
    .START_SPEED(vs), .PROG_SPEED(vp), .ACCEL_RATE(acc), .DECEL_RATE(dec), .JERK_SET(jerk),
    .ACCEL_GO(goa), .DECEL_GO(god), .SPEED(speed), .ACCEL_NOW(anow), .BUSY(busy), .DONE(done),
    .SHAPE(shape));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_t(input string nm, input real e, input int g);
    comparisons++;
    if (g < e * 0.95 - 3 || g > e * 1.05 + 3)
    begin
      failures++;
      $display("BAD %s expected %0.1f seen %0d", nm, e, g);
    end
  endtask
  // Phase length in ticks from the jerk relation and midpoint symmetry
  function automatic real exp_t(input row_t r);
    real a, dv, j, t;
    a = r.dn ? r.d : r.a;
    dv = r.vp - r.vs;
    j = r.j * a / 100.0;
    if (r.j == 0)
      return 1000.0 * dv / a;
    t = $sqrt(dv / j);
    if (j * t <= a)
      return 2000.0 * t;
    return 2000.0 * (a / j + (dv / 2 - a * a / (2 * j)) / a);
  endfunction
  // One phase; mode 1 repeats the request in mid-phase, which must be ignored,
  // mode 2 drops the clock enable for about three ticks, which must freeze speed and busy
  task automatic run(input row_t r, input int mode);
    logic [31:0] held;
    n = 0;
    held = 32'h0;
    {jin, ain, din, vsin, vpin, rdec, req} = {r.j, r.a, r.d, r.vs, r.vp, r.dn, 1'b1};
    do
    begin
      @(posedge clk);
      #1 n++;
      req = (mode == 1) && n == 100;
      en = !(mode == 2 && n >= 100 && n < 160);
      if (n == 100)
        held = speed;
      if (mode == 2 && n == 159)
      begin
        chk("frozen speed", held, speed);
        chk("frozen busy", 32'h1, {31'h0, busy});
      end
    end while (done !== 1'b1 && n < 20000);
    chk("phase done", 32'h1, {31'h0, done});
    chk_t("phase ticks", exp_t(r), n / TCK);
    chk("shape", r.sh, shape);
    chk("end speed", r.dn ? r.vs : r.vp, speed);
    chk("end accel", 0, anow);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    chk("reset speed", 0, speed);
    chk("reset accel", 32'h0, anow);
    chk("reset flags", 32'h0, {28'h0, busy, done, shape});
    foreach (rows[i])
      run(rows[i], 0);
    run(rows[0], 1);
    // Reset in mid-phase returns all outputs to rest
    {jin, rdec, req} = {16'hc8, 1'b0, 1'b1};
    repeat (50) @(posedge clk);
    #1 {req, rstn} = 2'b00;
    chk("mid busy", 32'h1, {31'h0, busy});
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    chk("mid reset speed", 32'h0, speed);
    chk("mid reset accel", 32'h0, anow);
    chk("mid reset flags", 32'h0, {28'h0, busy, done, shape});
    run(rows[2], 0);
    run(rows[1], 2);
    stop_test;
  end
  // Watchdog at about twice the expected run length
  initial
  begin
    #800000;
    failures++;
    stop_test;
  end
endmodule
